// ---- verilog/ddrci_pkg.sv ----
package ddrci_pkg;
   localparam int ADDR_W = 16;
   localparam int BA_W = 3;
   localparam int DQ_W = 16;
   localparam int DM_W = DQ_W / 8;
   localparam int NBANK = 8;
   // Command codes on {ras_n, cas_n, we_n} with the chip selected.
   localparam logic [2:0] CMD_MRS = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // Address field positions.
   localparam int A_AP = 10;
   localparam int A_BC = 12;
   localparam int COL_W = 10;
   // Mode register fields.
   localparam logic [1:0] MR0_BL_FIX8 = 2'h0;
   localparam logic [1:0] MR0_BL_OTF = 2'h1;
   localparam int MR1_RTT_0 = 2;
   localparam int MR1_RTT_1 = 6;
   localparam int MR1_RTT_2 = 9;
   localparam logic [3:0] BEATS_BL8 = 4'h8;
   localparam logic [3:0] BEATS_BC4 = 4'h4;
   // Register byte offsets.
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_STATUS = 6'h04;
   localparam logic [5:0] REG_MR0 = 6'h08;
   localparam logic [5:0] REG_MR1 = 6'h0C;
   localparam logic [5:0] REG_MR2 = 6'h10;
   localparam logic [5:0] REG_MR3 = 6'h14;
   localparam logic [5:0] REG_WRBEAT = 6'h18;
   localparam logic [5:0] REG_CMDCNT = 6'h1C;
   localparam logic [5:0] REG_LASTCMD = 6'h20;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int CTRL_EN_BIT = 0;

   typedef enum logic [1:0] {PWR_ON, PWR_PD_PRE, PWR_PD_ACT, PWR_SREF} ddrci_pwr_e;

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic odt;
      logic [DM_W-1:0] dm;
      logic [DQ_W-1:0] dq;
      logic wbeat;
   } ddrci_pins_s;

   typedef struct packed {
      ddrci_pwr_e pwr;
      logic [NBANK-1:0] open;
      logic [3:0][ADDR_W-1:0] mr;
      logic [BA_W-1:0] last_ba;
      logic [COL_W-1:0] last_col;
      logic last_ap;
      logic last_bl8;
      logic [DQ_W-1:0] wr_data;
      logic [DM_W-1:0] wr_be;
      logic [15:0] cmd_cnt;
      logic term;
   } ddrci_snap_s;
endpackage : ddrci_pkg

// ---- verilog/ddrci_top.sv ----
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module ddrci_top
   import ddrci_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic ck_i,
   input wire ddrci_pins_s pins_i,
   output logic term_en_o
);

   typedef struct packed {
      logic rst_m;
      logic rst_s;
      logic en_m;
      logic en_s;
      logic ack_m;
      logic ack_s;
      logic cke_m;
      logic cke_s;
      logic [3:0] beats_left;
      logic req;
      logic busy;
      logic term_en;
      ddrci_snap_s live;
      ddrci_snap_s snap;
   } ddrci_link_s;

   typedef struct packed {
      logic req_m;
      logic req_s;
      logic req_seen;
      logic ack;
      logic en;
      logic waitreq;
      logic [31:0] rdata;
      ddrci_snap_s snap;
   } ddrci_core_s;

   ddrci_link_s lq;
   ddrci_link_s ld;
   ddrci_core_s cq;
   ddrci_core_s cd;

   logic [2:0] cmd;
   logic sel;
   logic rtt_on;

   function automatic logic [31:0] read_mux(input logic [5:0] a, input ddrci_core_s s);
      logic [31:0] r;
      r = 32'h0;
      case (a)
         REG_CTRL: r = {31'h0, s.en};
         REG_STATUS: r = {15'h0, s.snap.term, s.snap.open, 6'h0, s.snap.pwr};
         REG_MR0: r = {16'h0, s.snap.mr[0]};
         REG_MR1: r = {16'h0, s.snap.mr[1]};
         REG_MR2: r = {16'h0, s.snap.mr[2]};
         REG_MR3: r = {16'h0, s.snap.mr[3]};
         REG_WRBEAT: r = {14'h0, s.snap.wr_be, s.snap.wr_data};
         REG_CMDCNT: r = {16'h0, s.snap.cmd_cnt};
         REG_LASTCMD: r = {17'h0, s.snap.last_bl8, s.snap.last_ap, s.snap.last_ba,
                           s.snap.last_col};
         default: r = 32'h0;
      endcase
      return r;
   endfunction : read_mux

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: command decode on the memory clock.

   // Chip select is part of the command; decode also stops when software disables it.
   assign cmd = {pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
   assign sel = !pins_i.cs_n && lq.en_s;
   assign rtt_on = lq.live.mr[1][MR1_RTT_0] | lq.live.mr[1][MR1_RTT_1] |
                   lq.live.mr[1][MR1_RTT_2];

   always_comb begin
      ld = lq;
      ld.rst_m = rst_i;
      ld.rst_s = lq.rst_m;
      ld.en_m = cq.en;
      ld.en_s = lq.en_m;
      ld.ack_m = cq.ack;
      ld.ack_s = lq.ack_m;
      // Clock enable also passes a synchroniser: self-refresh exit is asynchronous.
      ld.cke_m = pins_i.cke;
      ld.cke_s = lq.cke_m;
      if (lq.rst_s) begin
         ld.beats_left = 4'h0;
         ld.req = 1'b0;
         ld.busy = 1'b0;
         ld.term_en = 1'b0;
         ld.live = '0;
         ld.live.pwr = PWR_ON;
         ld.snap = '0;
         ld.snap.pwr = PWR_ON;
      end else begin
         case (lq.live.pwr)
            PWR_ON: begin
               if (!pins_i.cke) begin
                  if (sel && cmd == CMD_REF) begin
                     ld.live.pwr = PWR_SREF;
                     // The second stage still holds the high level from before entry;
                     // clearing it makes exit wait for a fresh rise of clock enable.
                     ld.cke_s = 1'b0;
                  end else if (lq.live.open == '0) begin
                     ld.live.pwr = PWR_PD_PRE;
                  end else begin
                     ld.live.pwr = PWR_PD_ACT;
                  end
               end else if (sel) begin
                  if (cmd != CMD_NOP) begin
                     ld.live.cmd_cnt = lq.live.cmd_cnt + 16'h1;
                  end
                  case (cmd)
                     CMD_MRS: begin
                        ld.live.mr[pins_i.ba[1:0]] = pins_i.addr;
                     end
                     CMD_PRE: begin
                        if (pins_i.addr[A_AP]) begin
                           ld.live.open = '0;
                        end else begin
                           ld.live.open[pins_i.ba] = 1'b0;
                        end
                     end
                     CMD_ACT: begin
                        ld.live.open[pins_i.ba] = 1'b1;
                     end
                     CMD_RD, CMD_WR: begin
                        ld.live.last_ba = pins_i.ba;
                        ld.live.last_col = pins_i.addr[COL_W-1:0];
                        ld.live.last_ap = pins_i.addr[A_AP];
                        if (lq.live.mr[0][1:0] == MR0_BL_OTF) begin
                           ld.live.last_bl8 = pins_i.addr[A_BC];
                        end else begin
                           ld.live.last_bl8 = (lq.live.mr[0][1:0] == MR0_BL_FIX8);
                        end
                        if (pins_i.addr[A_AP]) begin
                           ld.live.open[pins_i.ba] = 1'b0;
                        end
                        if (cmd == CMD_WR) begin
                           ld.beats_left = ld.live.last_bl8 ? BEATS_BL8 : BEATS_BC4;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            PWR_PD_PRE, PWR_PD_ACT: begin
               if (pins_i.cke) begin
                  ld.live.pwr = PWR_ON;
               end
            end
            PWR_SREF: begin
               if (lq.cke_s) begin
                  ld.live.pwr = PWR_ON;
               end
            end
            default: ld.live.pwr = PWR_ON;
         endcase
         // Beats with the mask high leave the stored byte untouched.
         if (lq.beats_left != 4'h0 && pins_i.wbeat && lq.live.pwr == PWR_ON) begin
            for (int i = 0; i < DM_W; i++) begin
               if (!pins_i.dm[i]) begin
                  ld.live.wr_data[i*8 +: 8] = pins_i.dq[i*8 +: 8];
               end
            end
            ld.live.wr_be = ~pins_i.dm;
            ld.beats_left = lq.beats_left - 4'h1;
         end
         // ODT stays live in power-down but its buffer is off in self refresh.
         ld.term_en = (lq.live.pwr != PWR_SREF) && rtt_on && pins_i.odt;
         ld.live.term = ld.term_en;
         // Snapshot handshake: the word stays frozen until the core acknowledges it,
         // so status lags the link by a few cycles of both clocks.
         if (lq.busy && lq.ack_s == lq.req) begin
            ld.busy = 1'b0;
         end else if (!lq.busy && lq.live != lq.snap) begin
            ld.snap = lq.live;
            ld.req = ~lq.req;
            ld.busy = 1'b1;
         end
      end
   end

   always_ff @(posedge ck_i) begin
      lq <= ld;
   end

   // Termination drives only the data, strobe and mask pads.
   assign term_en_o = lq.term_en;

   ////////////////////////////////////////////////////////////////////////////////
   // Core domain: register slave and snapshot capture.

   always_comb begin
      cd = cq;
      cd.req_m = lq.req;
      cd.req_s = cq.req_m;
      if (rst_i) begin
         cd.req_seen = 1'b0;
         cd.ack = 1'b0;
         cd.en = CTRL_EN_RST;
         cd.waitreq = 1'b1;
         cd.rdata = 32'h0;
         cd.snap = '0;
      end else begin
         if (cq.req_s != cq.req_seen) begin
            cd.snap = lq.snap;
            cd.req_seen = cq.req_s;
            cd.ack = cq.req_s;
         end
         cd.waitreq = 1'b1;
         if ((avs_read_i || avs_write_i) && cq.waitreq) begin
            cd.waitreq = 1'b0;
            cd.rdata = avs_read_i ? read_mux(avs_address_i, cq) : 32'h0;
         end
         if (avs_write_i && !cq.waitreq && avs_address_i == REG_CTRL &&
             avs_byteenable_i[0]) begin
            cd.en = avs_writedata_i[CTRL_EN_BIT];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      cq <= cd;
   end

   assign avs_readdata_o = cq.rdata;
   assign avs_waitrequest_o = cq.waitreq;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence seq_sel_cmd(logic [2:0] c);
      lq.live.pwr == PWR_ON && pins_i.cke && sel && cmd == c;
   endsequence

   sequence seq_sref_enter;
      lq.live.pwr == PWR_ON && !pins_i.cke && sel && cmd == CMD_REF;
   endsequence

   sequence seq_pd_state;
      lq.live.pwr == PWR_PD_PRE || lq.live.pwr == PWR_PD_ACT;
   endsequence

   chk_pre_all: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sel_cmd(CMD_PRE) ##0 pins_i.addr[A_AP] |=> lq.live.open == '0)
      else $error("precharge all left a bank open");

   chk_pre_one: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sel_cmd(CMD_PRE) ##0 !pins_i.addr[A_AP] |=>
      lq.live.open == ($past(lq.live.open) & ~(8'h1 << $past(pins_i.ba))))
      else $error("single precharge touched the wrong bank");

   chk_mrs_load: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sel_cmd(CMD_MRS) |=> lq.live.mr[$past(pins_i.ba[1:0])] == $past(pins_i.addr))
      else $error("mode register not loaded from address");

   chk_otf_chop: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sel_cmd(CMD_RD) ##0 lq.live.mr[0][1:0] == MR0_BL_OTF |=>
      lq.live.last_bl8 == $past(pins_i.addr[A_BC]))
      else $error("burst chop does not follow A12");

   chk_auto_pre: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      (seq_sel_cmd(CMD_RD) or seq_sel_cmd(CMD_WR)) ##0 pins_i.addr[A_AP] |=>
      !lq.live.open[$past(pins_i.ba)] && lq.live.last_col == $past(pins_i.addr[COL_W-1:0]))
      else $error("auto precharge or column wrong");

   chk_cs_mask: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.live.pwr == PWR_ON && pins_i.cke && pins_i.cs_n |=> $stable(lq.live.cmd_cnt))
      else $error("command decoded while deselected");

   chk_sref_cycle: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sref_enter |=> lq.live.pwr == PWR_SREF ##1
      (lq.live.pwr == PWR_SREF || $past(lq.cke_s)))
      else $error("self refresh entry or hold wrong");

   chk_sref_exit: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.live.pwr == PWR_SREF && lq.cke_s |=> lq.live.pwr == PWR_ON)
      else $error("self refresh not left on clock enable");

   chk_odt_off: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      !rtt_on || lq.live.pwr == PWR_SREF |=> !term_en_o)
      else $error("termination on while disabled");

   chk_mask_beat: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.beats_left != 4'h0 && pins_i.wbeat && pins_i.dm == '1 |=>
      $stable(lq.live.wr_data) && lq.live.wr_be == '0)
      else $error("masked beat was stored");

   chk_bus_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1
      avs_waitrequest_o)
      else $error("bus answer not one cycle after request");

   chk_act_open: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sel_cmd(CMD_ACT) |=> lq.live.open[$past(pins_i.ba)])
      else $error("activate did not open the addressed bank");

   chk_pd_pre: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.live.pwr == PWR_ON && !pins_i.cke && !(sel && cmd == CMD_REF) &&
      lq.live.open == '0 |=> lq.live.pwr == PWR_PD_PRE)
      else $error("idle banks did not enter precharge power-down");

   chk_pd_act: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.live.pwr == PWR_ON && !pins_i.cke && !(sel && cmd == CMD_REF) &&
      lq.live.open != '0 |=> lq.live.pwr == PWR_PD_ACT)
      else $error("open row did not enter active power-down");

   chk_pd_exit: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_pd_state ##0 pins_i.cke |=> lq.live.pwr == PWR_ON)
      else $error("power-down not left on clock enable");

   chk_pd_hold: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_pd_state ##0 !pins_i.cke |=> $stable(lq.live.open) && $stable(lq.live.cmd_cnt) &&
      $stable(lq.live.pwr))
      else $error("command decoded during power-down");

   chk_sref_hold: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.live.pwr == PWR_SREF && !lq.cke_s |=> lq.live.pwr == PWR_SREF &&
      $stable(lq.live.open) && $stable(lq.live.cmd_cnt))
      else $error("self refresh left or command decoded");

   chk_sref_fresh: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sref_enter |=> !lq.cke_s)
      else $error("stale clock enable seen at self refresh entry");

   chk_odt_on: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.live.pwr != PWR_SREF && rtt_on && pins_i.odt |=> term_en_o)
      else $error("termination off while requested");

   chk_wr_arm: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      seq_sel_cmd(CMD_WR) ##0 lq.beats_left == 4'h0 |=>
      lq.beats_left == (lq.live.last_bl8 ? BEATS_BL8 : BEATS_BC4))
      else $error("write armed the wrong beat count");

   chk_beat_count: assert property (@(posedge ck_i) disable iff (lq.rst_s)
      lq.beats_left != 4'h0 && pins_i.wbeat && lq.live.pwr == PWR_ON |=>
      lq.beats_left == $past(lq.beats_left) - 4'h1)
      else $error("write beat not consumed");

   chk_ctrl_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL && avs_byteenable_i[0]
      |=> cq.en == $past(avs_writedata_i[CTRL_EN_BIT]))
      else $error("control enable not written");

endmodule : ddrci_top

// ---- dv/ddrci_ctrl_model.sv ----
`timescale 1ns/1ps
module ddrci_ctrl_model
   import ddrci_pkg::*;
(
   input wire logic ck_i,
   output ddrci_pins_s pins_o
);
   logic [NBANK-1:0] open_q;
   initial begin
      pins_o = '0;
      pins_o.cs_n = 1'b1;
      pins_o.cke = 1'b1;
      {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = CMD_NOP;
      open_q = '0;
   end
   ////////////////////////////////////////////////////////////////
   // Released bank and address lines are inverted so a stale value never looks valid; select and command go back to deselect and NOP.
   task cmd(input logic cs_n, input logic [2:0] c, input logic [2:0] ba, input logic [15:0] a);
      @(posedge ck_i);
      pins_o.cs_n <= cs_n;
      {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= c;
      pins_o.ba <= ba;
      pins_o.addr <= a;
      @(posedge ck_i);
      pins_o.cs_n <= 1'b1;
      {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= CMD_NOP;
      pins_o.ba <= ~ba;
      pins_o.addr <= ~a;
      if (!cs_n && c == CMD_ACT) open_q[ba] = 1'b1;
      if (!cs_n && c == CMD_PRE) open_q = a[A_AP] ? '0 : open_q & ~(8'h01 << ba);
   endtask : cmd
   task rw(input logic wr, input logic [2:0] ba, input logic [9:0] col, input logic ap,
           input logic bl8);
      if (!open_q[ba]) cmd(1'b0, CMD_ACT, ba, 16'h0123);
      cmd(1'b0, wr ? CMD_WR : CMD_RD, ba, {3'h0, bl8, 1'b0, ap, col});
      if (ap) open_q[ba] = 1'b0;
   endtask : rw
   task beats(input int n, input logic [15:0] d0, input logic [1:0] m);
      for (int i = 0; i < n; i++) begin
         @(posedge ck_i);
         pins_o.wbeat <= 1'b1;
         pins_o.dq <= d0 + 16'(i);
         pins_o.dm <= m;
      end
      @(posedge ck_i);
      pins_o.wbeat <= 1'b0;
      pins_o.dq <= ~pins_o.dq;
      pins_o.dm <= ~m;
   endtask : beats
   task lvl(input logic cke, input logic odt);
      @(posedge ck_i);
      pins_o.cke <= cke;
      pins_o.odt <= odt;
   endtask : lvl
   task sleep();
      cmd(1'b0, CMD_PRE, 3'h0, 16'h0400);
      @(posedge ck_i);
      pins_o.cke <= 1'b0;
      pins_o.cs_n <= 1'b0;
      {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= CMD_REF;
      @(posedge ck_i);
      pins_o.cs_n <= 1'b1;
      {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= CMD_NOP;
   endtask : sleep
endmodule : ddrci_ctrl_model

// ---- dv/ddrci_top_tb.sv ----
`timescale 1ns/1ps
module ddrci_top_tb
   import ddrci_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic ck_i = 1'b0;
   logic rst_i = 1'b1;
   logic [5:0] avs_address_i = '0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = '0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic term_en_o;
   ddrci_pins_s pins_w;
   logic [31:0] d;
   logic [15:0] mrv [4] = '{16'h0001, 16'h0000, 16'h0018, 16'h0004};
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #2 core_clk_i = ~core_clk_i;
   initial begin
      #0.7;
      // The bench link runs slower than the board rate; decode has no speed dependence.
      forever #3 ck_i = ~ck_i;
   end
   ddrci_ctrl_model ctrl_u (.ck_i(ck_i), .pins_o(pins_w));
   ddrci_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .ck_i(ck_i), .pins_i(pins_w),
      .term_en_o(term_en_o));
   ////////////////////////////////////////////////////////////////
   task results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task rd(input logic [5:0] a, output logic [31:0] q);
      @(posedge core_clk_i);
      avs_address_i <= a;
      avs_read_i <= 1'b1;
      do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
   endtask : rd
   task wr(input logic [5:0] a, input logic [31:0] v, input logic [3:0] be);
      @(posedge core_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= v;
      avs_byteenable_i <= be;
      avs_write_i <= 1'b1;
      do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
   endtask : wr
   task rchk(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a, d);
      chk(nm, e, d & m);
   endtask : rchk
   // Status crosses from the link by handshake, so give it time to land.
   task settle();
      repeat (24) @(posedge core_clk_i);
   endtask : settle
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      // Three core cycles still give the link two reset edges through its synchroniser.
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      settle();
      chk("waitrequest", 32'h1, {31'h0, avs_waitrequest_o});
      rchk("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h1);
      rchk("cmdcnt", REG_CMDCNT, 32'hFFFFFFFF, 32'h0);
      rchk("unmapped", 6'h3C, 32'hFFFFFFFF, 32'h0);
      wr(REG_STATUS, 32'hFFFFFFFF, 4'hF);
      rchk("status", REG_STATUS, 32'hFFFFFFFF, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) ctrl_u.cmd(1'b0, CMD_MRS, 3'(i), mrv[i]);
      settle();
      for (int i = 0; i < 4; i++) rchk("mr", REG_MR0 + 6'(4 * i), 32'hFFFF, {16'h0, mrv[i]});
      rchk("cmdcnt", REG_CMDCNT, 32'hFFFFFFFF, 32'h4);
      $display("test mode load done");
      ctrl_u.rw(1'b1, 3'h2, 10'h155, 1'b0, 1'b1);
      ctrl_u.beats(8, 16'h1200, 2'b10);
      settle();
      rchk("lastcmd", REG_LASTCMD, 32'h7FFF, 32'h4955);
      rchk("wrbeat", REG_WRBEAT, 32'h300FF, 32'h10007);
      rchk("open", REG_STATUS, 32'hFF03, 32'h0400);
      ctrl_u.rw(1'b1, 3'h5, 10'h2AA, 1'b1, 1'b0);
      ctrl_u.beats(6, 16'h3400, 2'b00);
      settle();
      rchk("lastcmd", REG_LASTCMD, 32'h7FFF, 32'h36AA);
      rchk("wrbeat", REG_WRBEAT, 32'h3FFFF, 32'h33403);
      rchk("open", REG_STATUS, 32'hFF03, 32'h0400);
      ctrl_u.rw(1'b1, 3'h5, 10'h0AA, 1'b1, 1'b0);
      ctrl_u.beats(4, 16'h5600, 2'b11);
      settle();
      rchk("wrbeat", REG_WRBEAT, 32'h3FFFF, 32'h03403);
      ctrl_u.rw(1'b0, 3'h7, 10'h011, 1'b0, 1'b1);
      ctrl_u.cmd(1'b0, CMD_PRE, 3'h2, 16'h0000);
      settle();
      rchk("lastcmd", REG_LASTCMD, 32'h7FFF, 32'h5C11);
      rchk("open", REG_STATUS, 32'hFF03, 32'h8000);
      $display("test access done");
      rchk("cmdcnt", REG_CMDCNT, 32'hFFFFFFFF, 32'hD);
      ctrl_u.cmd(1'b1, CMD_ACT, 3'h0, 16'h0001);
      wr(REG_CTRL, 32'h0, 4'h0);
      rchk("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h1);
      wr(REG_CTRL, 32'h0, 4'hF);
      // The enable crosses into the link domain; let it land before the masked command.
      settle();
      rchk("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h0);
      ctrl_u.cmd(1'b0, CMD_ACT, 3'h0, 16'h0001);
      wr(REG_CTRL, 32'h1, 4'h1);
      settle();
      rchk("cmdcnt", REG_CMDCNT, 32'hFFFFFFFF, 32'hD);
      rchk("open", REG_STATUS, 32'hFF03, 32'h8000);
      $display("test select done");
      ctrl_u.lvl(1'b1, 1'b1);
      settle();
      chk("term", 32'h0, {31'h0, term_en_o});
      ctrl_u.cmd(1'b0, CMD_MRS, 3'h1, 16'h0004);
      settle();
      chk("term", 32'h1, {31'h0, term_en_o});
      rchk("term_stat", REG_STATUS, 32'h10000, 32'h10000);
      $display("test termination done");
      ctrl_u.lvl(1'b0, 1'b1);
      settle();
      rchk("pwr", REG_STATUS, 32'hFF03, 32'h8002);
      chk("term", 32'h1, {31'h0, term_en_o});
      ctrl_u.lvl(1'b1, 1'b1);
      ctrl_u.cmd(1'b0, CMD_PRE, 3'h0, 16'h0400);
      ctrl_u.lvl(1'b0, 1'b1);
      ctrl_u.cmd(1'b0, CMD_ACT, 3'h4, 16'h0001);
      settle();
      rchk("pwr", REG_STATUS, 32'hFF03, 32'h0001);
      ctrl_u.lvl(1'b1, 1'b1);
      settle();
      rchk("pwr", REG_STATUS, 32'h3, 32'h0);
      ctrl_u.sleep();
      settle();
      rchk("pwr", REG_STATUS, 32'hFF03, 32'h0003);
      chk("term", 32'h0, {31'h0, term_en_o});
      ctrl_u.lvl(1'b1, 1'b0);
      settle();
      rchk("pwr", REG_STATUS, 32'h3, 32'h0);
      $display("test power done");
      results();
   end
endmodule : ddrci_top_tb
